// File: rtl/bdcfg_top.sv
// bdcfg_top.sv: button direction configuration over the tag mailbox, press/release encoding and advertising timing
// assumes one-cycle mailbox write/read strobes from the tag front end on core_clk_i; spring contacts are pins
//
// Contract
// - with the default setting a spring move away from the board is a press and toward it a release.
// - a setting of 0x01 reverses that, so toward the board is a press and away a release.
// - a setting of 0x00 keeps the standard encoding.
// - a write of first byte 0x19 to block 0x0050 opens a configuration request by the second-level user.
// - the four-byte PIN written to block 0x0052 then authenticates the pending request.
// - a write to block 0x0051 with last byte 0x10 selects the button setting register.
// - the first byte of a write to block 0x0054, others zero, loads the selected register.
// - a read of block 0x002C returns four bytes with the setting in the first byte.
// - advertising events are spaced 20 ms by default and 10 ms when the fast setting is selected.
// - each event is three telegrams of about 0.5 ms on three channels, about 2.5 ms in all.
// - events go out on the standard advertising channels or on user-chosen channels.
`timescale 1ns/10ps
`include "bdcfg_regs.svh"
module bdcfg_top
  import bdcfg_pkg::*;
#(
  parameter logic [31:0] USER_PIN = `BDCFG_PIN_RST, // arbitrary value, set per unit
  parameter int unsigned SLOW_CYC = `BDCFG_SPACING_SLOW_CYC,
  parameter int unsigned FAST_CYC = `BDCFG_SPACING_FAST_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        mbx_wr_i,
  input  wire logic        mbx_rd_i,
  input  wire logic [15:0] mbx_blk_i,
  input  wire logic [31:0] mbx_wdata_i,
  input  wire logic        spring_away_i,
  input  wire logic        spring_toward_i,
  input  wire logic        fast_spacing_i,
  input  wire logic        user_channels_i,
  output logic [31:0]      mbx_rdata_o,
  output logic             mbx_rvalid_o,
  output logic             auth_ok_o,
  output logic             press_o,
  output logic             release_o,
  output logic             tx_on_o,
  output logic [1:0]       chan_o,
  output logic             user_chan_o
);
  // byte 0 of a mailbox word is the first byte on the air
  logic [7:0] b0;
  logic [7:0] b3;
  assign b0 = mbx_wdata_i[7:0];
  assign b3 = mbx_wdata_i[31:24];

  // spring contacts come from pins
  logic away_s;
  logic toward_s;
  bdcfg_sync u_sync_away (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .async_i    (spring_away_i),
    .sync_o     (away_s)
  );
  bdcfg_sync u_sync_toward (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .async_i    (spring_toward_i),
    .sync_o     (toward_s)
  );

  // configuration sequence state
  bdcfg_state_t st_r, st_nxt;
  logic [7:0]   setting_r, setting_nxt;
  logic [31:0]  rdata_r, rdata_nxt;
  logic         rvalid_r, rvalid_nxt;
  logic         auth_r, auth_nxt;

  always_comb begin
    st_nxt      = st_r;
    setting_nxt = setting_r;
    if (mbx_wr_i) begin
      if (mbx_blk_i == `BDCFG_BLK_IDENTIFY) begin
        // a fresh identify always restarts the sequence
        st_nxt = (b0 == `BDCFG_IDENT_CODE) ? BDCFG_ST_IDENT : BDCFG_ST_IDLE;
      end else begin
        unique case (st_r)
          BDCFG_ST_IDLE: st_nxt = BDCFG_ST_IDLE;
          BDCFG_ST_IDENT: begin
            if (mbx_blk_i == `BDCFG_BLK_PIN && mbx_wdata_i == USER_PIN) st_nxt = BDCFG_ST_AUTH;
            else st_nxt = BDCFG_ST_IDLE;
          end
          BDCFG_ST_AUTH, BDCFG_ST_TARGET, BDCFG_ST_VALUE: begin
            if (mbx_blk_i == `BDCFG_BLK_TARGET) begin
              // other targets leave the session open but deselect this register
              st_nxt = (b3 == `BDCFG_TARGET_CODE) ? BDCFG_ST_TARGET : BDCFG_ST_AUTH;
            end else if (mbx_blk_i == `BDCFG_BLK_VALUE && st_r != BDCFG_ST_AUTH) begin
              if (mbx_wdata_i[31:8] == 24'h000000) begin
                setting_nxt = b0;
                st_nxt      = BDCFG_ST_VALUE;
              end
            end else if (mbx_blk_i == `BDCFG_BLK_PIN && mbx_wdata_i != USER_PIN) begin
              st_nxt = BDCFG_ST_IDLE;
            end
          end
        endcase
      end
    end
    // the authenticated flag is a flop of its own so the pin never sees decode glitches
    auth_nxt = (st_nxt == BDCFG_ST_AUTH) || (st_nxt == BDCFG_ST_TARGET) || (st_nxt == BDCFG_ST_VALUE);
  end

  // readback of the setting register
  always_comb begin
    rvalid_nxt = mbx_rd_i;
    rdata_nxt  = rdata_r;
    if (mbx_rd_i) begin
      rdata_nxt = (mbx_blk_i == `BDCFG_BLK_SETTING) ? {24'h000000, setting_r} : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_r      <= BDCFG_ST_IDLE;
      setting_r <= `BDCFG_SETTING_RST; // standard encoding out of reset
      rdata_r   <= 32'h0000_0000;
      rvalid_r  <= 1'b0;
      auth_r    <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      setting_r <= setting_nxt;
      rdata_r   <= rdata_nxt;
      rvalid_r  <= rvalid_nxt;
      auth_r    <= auth_nxt;
    end
  end

  // direction encoding; any value other than 0x01 is treated as standard
  logic inv;
  logic away_d_r, toward_d_r;
  logic press_r, press_nxt, release_r, release_nxt;
  logic away_edge, toward_edge;
  assign inv         = (setting_r == `BDCFG_DIR_INVERTED);
  assign away_edge   = away_s & ~away_d_r;
  assign toward_edge = toward_s & ~toward_d_r;

  always_comb begin
    press_nxt   = inv ? toward_edge : away_edge;
    release_nxt = inv ? away_edge : toward_edge;
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      away_d_r   <= 1'b0;
      toward_d_r <= 1'b0;
      press_r    <= 1'b0;
      release_r  <= 1'b0;
    end else begin
      away_d_r   <= away_s;
      toward_d_r <= toward_s;
      press_r    <= press_nxt;
      release_r  <= release_nxt;
    end
  end

  // advertising sequencer; started by a reported action while it is idle
  logic       adv_tx;
  logic [1:0] adv_ch;
  logic       tx_r, ucr_r;
  logic [1:0] ch_r;
  bdcfg_adv #(
    .SLOW_CYC (SLOW_CYC),
    .FAST_CYC (FAST_CYC),
    .TLG_CYC  (`BDCFG_TELEGRAM_CYC),
    .GAP_CYC  (`BDCFG_GAP_CYC),
    .EVENTS   (3)
  ) u_adv (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .start_i    (press_r | release_r),
    .fast_i     (fast_spacing_i),
    .tx_on_o    (adv_tx),
    .chan_o     (adv_ch),
    .busy_o     ()
  );

  // channel set choice rides with each telegram, registered for clean outputs
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tx_r  <= 1'b0;
      ch_r  <= 2'h0;
      ucr_r <= 1'b0;
    end else begin
      tx_r  <= adv_tx;
      ch_r  <= adv_ch;
      ucr_r <= user_channels_i;
    end
  end

  assign mbx_rdata_o  = rdata_r;
  assign mbx_rvalid_o = rvalid_r;
  assign auth_ok_o    = auth_r;
  assign press_o      = press_r;
  assign release_o    = release_r;
  assign tx_on_o      = tx_r;
  assign chan_o       = ch_r;
  assign user_chan_o  = ucr_r;

  // helper for the telegram length checks: cycles the current telegram has stood on the pin;
  // 16 bits cover one telegram, a stuck telegram trips the bound long before it wraps
  logic [15:0] tx_run_r;
  logic [15:0] tx_run_nxt;

  always_comb begin
    tx_run_nxt = tx_r ? (tx_run_r + 16'h1) : 16'h0;
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tx_run_r <= 16'h0000;
    end else begin
      tx_run_r <= tx_run_nxt;
    end
  end

  // steps of a configuration session, one mailbox write each;
  // the session properties below are built from these
  // step one: identify request
  sequence bdcfg_seq_ident;
    mbx_wr_i && (mbx_blk_i == `BDCFG_BLK_IDENTIFY) && (b0 == `BDCFG_IDENT_CODE);
  endsequence

  // step two: matching pin right after the identify
  sequence bdcfg_seq_pin_ok;
    (st_r == BDCFG_ST_IDENT) && mbx_wr_i && (mbx_blk_i == `BDCFG_BLK_PIN) && (mbx_wdata_i == USER_PIN);
  endsequence

  // step two gone wrong: any other pin
  sequence bdcfg_seq_pin_bad;
    (st_r == BDCFG_ST_IDENT) && mbx_wr_i && (mbx_blk_i == `BDCFG_BLK_PIN) && (mbx_wdata_i != USER_PIN);
  endsequence

  // step three: select the button setting inside an open session
  sequence bdcfg_seq_select;
    auth_ok_o && mbx_wr_i && (mbx_blk_i == `BDCFG_BLK_TARGET) && (b3 == `BDCFG_TARGET_CODE);
  endsequence

  // step four: a clean value word once the register is selected
  sequence bdcfg_seq_load;
    ((st_r == BDCFG_ST_TARGET) || (st_r == BDCFG_ST_VALUE)) && mbx_wr_i && (mbx_blk_i == `BDCFG_BLK_VALUE)
      && (mbx_wdata_i[31:8] == 24'h000000);
  endsequence

  // direction encoding: one registered pulse per synced edge
  AST_INV_PRESS: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (inv && toward_edge) |=> press_o) else $error("toward move not press when inverted");
  AST_STD_PRESS: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!inv && away_edge) |=> press_o) else $error("away move not press in standard mode");
  AST_STD_REL: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (setting_r == 8'h00 && toward_edge) |=> release_o) else $error("toward move not release");
  AST_INV_REL: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (inv && away_edge) |=> release_o) else $error("away move not release when inverted");
  // a press is a single pulse, never a held level
  AST_PULSE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    press_o |=> !press_o) else $error("press pulse longer than one cycle");

  // configuration session
  // a fresh identify always lands in the identify step, whatever came before
  AST_IDENT: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    bdcfg_seq_ident |=> (st_r == BDCFG_ST_IDENT)) else $error("identify ignored");
  AST_AUTH: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    bdcfg_seq_pin_ok |=> auth_ok_o) else $error("pin not accepted");
  // a wrong pin drops the session
  AST_BADPIN: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    bdcfg_seq_pin_bad |=> !auth_ok_o) else $error("wrong pin accepted");
  AST_NOAUTH_LOAD: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (st_r != BDCFG_ST_TARGET && st_r != BDCFG_ST_VALUE) |=> $stable(setting_r)) else $error("load without select");
  // selection of the button setting opens the value step
  AST_TARGET: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    bdcfg_seq_select |=> (st_r == BDCFG_ST_TARGET)) else $error("target select ignored");
  // the first byte of a clean value word lands in the setting
  AST_LOAD: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    bdcfg_seq_load |=> (setting_r == $past(b0))) else $error("value not loaded");
  // a value word with stray upper bytes is refused
  AST_RSVD_NOLOAD: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (mbx_wr_i && (mbx_blk_i == `BDCFG_BLK_VALUE) && (mbx_wdata_i[31:8] != 24'h000000))
    |=> $stable(setting_r)) else $error("value with stray bytes loaded");
  // nothing but a value write moves the setting, so it survives every actuation
  AST_PERSIST: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !(mbx_wr_i && (mbx_blk_i == `BDCFG_BLK_VALUE)) |=> $stable(setting_r)) else $error("setting lost");
  AST_READ: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (mbx_rd_i && mbx_blk_i == 16'h002C) |=> mbx_rvalid_o && mbx_rdata_o == {24'h0, $past(setting_r)})
    else $error("readback wrong");
  AST_RVALID: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    mbx_rvalid_o |-> $past(mbx_rd_i)) else $error("read answer without a read");

  // advertising
  // three channels per event, never a fourth
  AST_CHAN3: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    chan_o != 2'h3) else $error("fourth channel used");
  // every telegram stands exactly its nominal length, unless reset cuts it
  AST_TLG_LEN: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    tx_run_r <= 16'(`BDCFG_TELEGRAM_CYC)) else $error("telegram too long");
  AST_TLG_END: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $fell(tx_r) |-> (tx_run_r == 16'(`BDCFG_TELEGRAM_CYC))) else $error("telegram too short");
  // the channel set choice follows its input one cycle late; the reset cycle is skipped
  AST_USER_CHAN: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!$past(sys_rst_i)) |-> (user_chan_o == $past(user_channels_i))) else $error("channel set choice lost");
endmodule : bdcfg_top

// File: rtl/bdcfg_regs.svh
// bdcfg_regs.svh: block numbers, field codes and timing counts of the button direction configuration block
// assumes a 25 MHz core clock; included by bare name with an include guard
`ifndef BDCFG_REGS_SVH
`define BDCFG_REGS_SVH

`define BDCFG_BLK_SETTING    16'h002C
`define BDCFG_BLK_IDENTIFY   16'h0050
`define BDCFG_BLK_TARGET     16'h0051
`define BDCFG_BLK_PIN        16'h0052
`define BDCFG_BLK_VALUE      16'h0054
`define BDCFG_IDENT_CODE     8'h19
`define BDCFG_TARGET_CODE    8'h10
`define BDCFG_DIR_STANDARD   8'h00
`define BDCFG_DIR_INVERTED   8'h01
`define BDCFG_SETTING_RST    8'h00
`define BDCFG_PIN_RST        32'h0000_0000
`define BDCFG_CLK_KHZ        25000
`define BDCFG_SPACING_SLOW_MS 20
`define BDCFG_SPACING_FAST_MS 10
`define BDCFG_TELEGRAM_US    500
`define BDCFG_EVENT_US       2500
`define BDCFG_SPACING_SLOW_CYC (`BDCFG_SPACING_SLOW_MS * `BDCFG_CLK_KHZ)
`define BDCFG_SPACING_FAST_CYC (`BDCFG_SPACING_FAST_MS * `BDCFG_CLK_KHZ)
`define BDCFG_TELEGRAM_CYC   ((`BDCFG_TELEGRAM_US * `BDCFG_CLK_KHZ) / 1000)
`define BDCFG_GAP_CYC        (((`BDCFG_EVENT_US - 3 * `BDCFG_TELEGRAM_US) * `BDCFG_CLK_KHZ) / 2000)

`endif

// File: rtl/bdcfg_pkg.sv
// bdcfg_pkg.sv: types shared by the button direction configuration block
// assumes bdcfg_regs.svh holds the block numbers, field codes and timing counts
package bdcfg_pkg;
  typedef enum logic [4:0] {
    BDCFG_ST_IDLE   = 5'b00001,
    BDCFG_ST_IDENT  = 5'b00010,
    BDCFG_ST_AUTH   = 5'b00100,
    BDCFG_ST_TARGET = 5'b01000,
    BDCFG_ST_VALUE  = 5'b10000
  } bdcfg_state_t;

  typedef enum logic [3:0] {
    BDCFG_AD_IDLE = 4'b0001,
    BDCFG_AD_TX   = 4'b0010,
    BDCFG_AD_GAP  = 4'b0100,
    BDCFG_AD_WAIT = 4'b1000
  } bdcfg_adv_t;
endpackage : bdcfg_pkg

// File: rtl/bdcfg_sync.sv
// bdcfg_sync.sv: two-flop synchroniser for a level that arrives from a pin
// assumes the destination clock is core_clk_i; first flop read only by the second
`timescale 1ns/10ps
module bdcfg_sync (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_r;
  logic sync_r;
  logic meta_nxt;
  logic sync_nxt;

  // plain shift, kept apart from any decoding
  always_comb begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_o = sync_r;
endmodule : bdcfg_sync

// File: rtl/bdcfg_adv.sv
// bdcfg_adv.sv: advertising event sequencer, three telegrams on three channels per event
// assumes a one-cycle start pulse per spring action; 25 MHz clock
`timescale 1ns/10ps
`include "bdcfg_regs.svh"
module bdcfg_adv
  import bdcfg_pkg::*;
#(
  parameter int unsigned SLOW_CYC = `BDCFG_SPACING_SLOW_CYC,
  parameter int unsigned FAST_CYC = `BDCFG_SPACING_FAST_CYC,
  parameter int unsigned TLG_CYC  = `BDCFG_TELEGRAM_CYC,
  parameter int unsigned GAP_CYC  = `BDCFG_GAP_CYC,
  parameter int unsigned EVENTS   = 3
) (
  input  wire logic       core_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       start_i,
  input  wire logic       fast_i,
  output logic            tx_on_o,
  output logic [1:0]      chan_o,
  output logic            busy_o
);
  bdcfg_adv_t  st_r, st_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [31:0] evt_r, evt_nxt;
  logic [1:0]  ch_r, ch_nxt;
  logic [3:0]  ev_r, ev_nxt;
  logic [31:0] spacing;

  // spacing runs from one event start to the next, so the event itself lies inside it;
  // a spacing shorter than the event only makes events run back to back
  assign spacing = fast_i ? FAST_CYC : SLOW_CYC;

  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r + 32'h1;
    evt_nxt = evt_r + 32'h1;
    ch_nxt  = ch_r;
    ev_nxt  = ev_r;
    unique case (st_r)
      BDCFG_AD_IDLE: begin
        cnt_nxt = 32'h0;
        evt_nxt = 32'h0;
        if (start_i) begin
          st_nxt = BDCFG_AD_TX;
          ch_nxt = 2'h0;
          ev_nxt = 4'h0;
        end
      end
      BDCFG_AD_TX: begin
        if (cnt_r >= TLG_CYC - 1) begin
          if (ch_r == 2'h2) begin
            st_nxt = BDCFG_AD_WAIT; // three channels done
          end else begin
            st_nxt = BDCFG_AD_GAP;
          end
        end
      end
      BDCFG_AD_GAP: begin
        if (cnt_r >= TLG_CYC + GAP_CYC - 1) begin
          st_nxt  = BDCFG_AD_TX;  // channel change then next telegram
          ch_nxt  = ch_r + 2'h1;
          cnt_nxt = 32'h0;
        end
      end
      BDCFG_AD_WAIT: begin
        if (evt_r >= spacing - 32'h1) begin // event spacing 20 or 10 ms
          ch_nxt  = 2'h0;
          cnt_nxt = 32'h0;
          evt_nxt = 32'h0;
          ev_nxt  = ev_r + 4'h1;
          st_nxt  = (ev_r == 4'(EVENTS - 1)) ? BDCFG_AD_IDLE : BDCFG_AD_TX;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_r  <= BDCFG_AD_IDLE;
      cnt_r <= 32'h0;
      evt_r <= 32'h0;
      ch_r  <= 2'h0;
      ev_r  <= 4'h0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      evt_r <= evt_nxt;
      ch_r  <= ch_nxt;
      ev_r  <= ev_nxt;
    end
  end

  assign tx_on_o = (st_r == BDCFG_AD_TX);
  assign chan_o  = ch_r;
  assign busy_o  = (st_r != BDCFG_AD_IDLE);

  // a new event may only follow once the chosen spacing has run out since the last start
  AST_SPACING: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (st_r == BDCFG_AD_WAIT && st_nxt == BDCFG_AD_TX) |-> (evt_r >= spacing - 32'h1)) else $error("event spacing cut short");
endmodule : bdcfg_adv

// File: bench/bdcfg_rdr_model.sv
// bdcfg_rdr_model.sv: tag reader and scanner model facing the block
// assumes the block clock; strobes launched after a falling edge
`timescale 1ns/10ps
`include "bdcfg_regs.svh"
module bdcfg_rdr_model (
  input  wire logic        core_clk_i,
  input  wire logic [31:0] mbx_rdata_i,
  input  wire logic        mbx_rvalid_i,
  input  wire logic        tx_on_i,
  output logic             mbx_wr_o,
  output logic             mbx_rd_o,
  output logic [15:0]      mbx_blk_o,
  output logic [31:0]      mbx_wdata_o
);
  int unsigned heard;
  // released bus shows the inverse, so a stale block never looks valid
  initial begin
    mbx_wr_o = 1'b0;
    mbx_rd_o = 1'b0;
    mbx_blk_o = 16'hFFFF;
    mbx_wdata_o = 32'hFFFF_FFFF;
    heard = 0;
  end

  // listening never stops, wider than any window
  always @(posedge tx_on_i) begin
    heard = heard + 1;
  end

  task automatic wr_blk(input logic [15:0] blk, input logic [31:0] data);
    @(negedge core_clk_i);
    mbx_wr_o = 1'b1;
    mbx_blk_o = blk;
    mbx_wdata_o = data;
    @(negedge core_clk_i);
    mbx_wr_o = 1'b0;
    mbx_blk_o = ~blk;
    mbx_wdata_o = ~data;
  endtask : wr_blk

  // answer is taken one cycle after the strobe; none gives unknown
  task automatic rd_blk(input logic [15:0] blk, output logic [31:0] data);
    @(negedge core_clk_i);
    mbx_rd_o = 1'b1;
    mbx_blk_o = blk;
    @(negedge core_clk_i);
    mbx_rd_o = 1'b0;
    mbx_blk_o = ~blk;
    data = (mbx_rvalid_i === 1'b1) ? mbx_rdata_i : 'x;
  endtask : rd_blk

  task automatic session(input logic [31:0] pin, input logic [31:0] tgt, input logic [31:0] val);
    wr_blk(`BDCFG_BLK_IDENTIFY, {24'h00_0000, `BDCFG_IDENT_CODE});
    wr_blk(`BDCFG_BLK_PIN, pin);
    wr_blk(`BDCFG_BLK_TARGET, tgt);
    wr_blk(`BDCFG_BLK_VALUE, val);
  endtask : session
endmodule : bdcfg_rdr_model

// File: bench/tb_button_direction_config_and_adv_timing.sv
// tb: mailbox configuration, press/release encoding, first telegrams
// assumes shortened event spacing; telegram counts stay as built
`timescale 1ns/10ps
`include "bdcfg_regs.svh"
module tb_button_direction_config_and_adv_timing;
  localparam logic [31:0] PIN = 32'h5A3C_0F96; // arbitrary unit code
  localparam logic [31:0] TGT = 32'h1000_0000;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic away = 1'b0;
  logic toward = 1'b0;
  logic fast = 1'b0;
  logic user_ch = 1'b0;
  logic mbx_wr, mbx_rd, mbx_rvalid, auth_ok, press, rel, tx_on, user_chan;
  logic [15:0] mbx_blk;
  logic [31:0] mbx_wdata, mbx_rdata, rd;
  logic [1:0] chan;
  int err_count = 0;
  int checked = 0;

  always #20 core_clk = ~core_clk;

  bdcfg_top #(.USER_PIN(PIN), .SLOW_CYC(2000), .FAST_CYC(1000)) i_dut (
    .core_clk_i(core_clk), .sys_rst_i(sys_rst), .mbx_wr_i(mbx_wr), .mbx_rd_i(mbx_rd),
    .mbx_blk_i(mbx_blk), .mbx_wdata_i(mbx_wdata), .spring_away_i(away), .spring_toward_i(toward),
    .fast_spacing_i(fast), .user_channels_i(user_ch), .mbx_rdata_o(mbx_rdata),
    .mbx_rvalid_o(mbx_rvalid), .auth_ok_o(auth_ok), .press_o(press), .release_o(rel),
    .tx_on_o(tx_on), .chan_o(chan), .user_chan_o(user_chan));

  bdcfg_rdr_model i_rdr (
    .core_clk_i(core_clk), .mbx_rdata_i(mbx_rdata), .mbx_rvalid_i(mbx_rvalid), .tx_on_i(tx_on),
    .mbx_wr_o(mbx_wr), .mbx_rd_o(mbx_rd), .mbx_blk_o(mbx_blk), .mbx_wdata_o(mbx_wdata));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("compares=%0d mismatches=%0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic do_reset();
    @(negedge core_clk);
    sys_rst = 1'b1;
    repeat (5) @(negedge core_clk);
    sys_rst = 1'b0;
  endtask : do_reset

  // one spring move; returns {press, release} of the first pulse seen
  task automatic act(input logic to_away, output logic [31:0] pr);
    int n;
    pr = 32'h0;
    @(negedge core_clk);
    away = to_away;
    toward = ~to_away;
    for (n = 0; n < 10 && pr == 32'h0; n++) begin
      @(negedge core_clk);
      pr = {30'h0, press, rel};
    end
    away = 1'b0;
    toward = 1'b0;
    repeat (5) @(negedge core_clk);
  endtask : act

  task automatic t_default();
    i_rdr.rd_blk(`BDCFG_BLK_SETTING, rd);
    chk(rd, 32'h0000_0000);
    act(1'b1, rd);
    chk(rd, 32'h0000_0002);
    act(1'b0, rd);
    chk(rd, 32'h0000_0001);
  endtask : t_default

  task automatic t_invert();
    i_rdr.session(PIN, TGT, 32'h0000_0001);
    i_rdr.rd_blk(`BDCFG_BLK_SETTING, rd);
    chk(rd, 32'h0000_0001);
    act(1'b1, rd);
    chk(rd, 32'h0000_0001);
    act(1'b0, rd);
    chk(rd, 32'h0000_0002);
    act(1'b1, rd);
    chk(rd, 32'h0000_0001);
  endtask : t_invert

  // refused writes leave the inverted setting, then a clean value word after a correct select restores the standard setting
  task automatic t_refuse();
    i_rdr.session(~PIN, TGT, 32'h0000_0000);
    chk({31'h0, auth_ok}, 32'h0);
    i_rdr.wr_blk(`BDCFG_BLK_IDENTIFY, 32'h0000_0019);
    i_rdr.wr_blk(`BDCFG_BLK_PIN, PIN);
    chk({31'h0, auth_ok}, 32'h1);
    i_rdr.wr_blk(`BDCFG_BLK_TARGET, 32'h2000_0000);
    i_rdr.wr_blk(`BDCFG_BLK_VALUE, 32'h0000_0000);
    i_rdr.rd_blk(`BDCFG_BLK_SETTING, rd);
    chk(rd, 32'h0000_0001);
    i_rdr.wr_blk(`BDCFG_BLK_TARGET, TGT);
    i_rdr.wr_blk(`BDCFG_BLK_VALUE, 32'h0000_0100);
    i_rdr.rd_blk(`BDCFG_BLK_SETTING, rd);
    chk(rd, 32'h0000_0001);
    i_rdr.wr_blk(`BDCFG_BLK_VALUE, 32'h0000_0000);
    i_rdr.rd_blk(`BDCFG_BLK_SETTING, rd);
    chk(rd, 32'h0000_0000);
    act(1'b1, rd);
    chk(rd, 32'h0000_0002);
    user_ch = 1'b1;
    repeat (3) @(negedge core_clk);
    chk({31'h0, user_chan}, 32'h1);
  endtask : t_refuse

  // first two telegrams: length, gap and channel order
  task automatic t_adv();
    int n;
    int h0;
    do_reset();
    fast = 1'b1;
    h0 = i_rdr.heard;
    away = 1'b1;
    for (n = 0; n < 40 && tx_on !== 1'b1; n++) @(negedge core_clk);
    chk({30'h0, chan}, 32'h0);
    for (n = 0; n < 20000 && tx_on === 1'b1; n++) @(negedge core_clk);
    chk(n, 12500);
    for (n = 0; n < 20000 && tx_on !== 1'b1; n++) @(negedge core_clk);
    chk(n, 12500);
    chk({30'h0, chan}, 32'h1);
    chk(i_rdr.heard - h0, 2);
    away = 1'b0;
  endtask : t_adv

  // about 25k cycles expected; 50k cycles cut a hang with margin
  initial begin
    #2_000_000;
    err_count++;
    final_report();
  end

  initial begin
    do_reset();
    t_default();
    t_invert();
    t_refuse();
    t_adv();
    final_report();
  end
endmodule : tb_button_direction_config_and_adv_timing
